// [test_wdcm_top.sv]
// Self-checking bench for the watchdog with clock monitor
`timescale 1ns/1ps
`default_nettype none

module test_wdcm_top;
  import wdcm_pkg::*;
  // Stimulus and observation
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, pin, pin_o, pin_oe;
  logic icyc_en = 1'b1;
  logic sleep = 1'b0;
  logic [1:0] win;
  logic [7:0] bad[4] = '{8'h59, 8'h18, 8'h1b, 8'h19};
  int fails = 0;
  int check_count = 0;
  int t, n, hi_cnt = 0, hi_len = 0;

  always #20 mclk = ~mclk;

  // Small clock-monitor limit keeps the dead-clock test short
  wdcm_top #(.CM_LIMIT_CYC(200)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .icyc_en(icyc_en),
    .full_stop_mode(1'b0), .light_sleep_mode(sleep),
    .fault_output_pin_i(pin), .fault_output_pin_o(pin_o),
    .fault_output_pin_oe(pin_oe)
  );

  wdcm_fault_sink sink (.pin_o(pin_o), .pin_oe(pin_oe), .pin(pin));

  // Length of the last low pulse, so writes may overlap it
  always @(posedge mclk) begin
    if (pin_oe === 1'b1) begin
      hi_cnt <= hi_cnt + 1;
    end else begin
      if (hi_cnt > 0) hi_len <= hi_cnt;
      hi_cnt <= 0;
    end
  end

  // Expected service readback: key field always reads zero
  function automatic logic [31:0] exp_svc(input logic [1:0] w, input logic c);
    exp_svc = {24'h000000, w, 5'h00, c};
  endfunction

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One APB transfer; the request stands until the rising edge at which
  // pready is seen high, and the answer is taken at that same edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk("apb answer", 32'h1, 32'h0);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task svc(input logic [7:0] v);
    apb(1'b1, WDCM_OFS_SVC, {24'h000000, v});
  endtask

  // Bounded wait for the pin enable to reach v
  task wait_oe(input logic v, input int lim, output int c);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (pin_oe !== v && c < lim);
  endtask

  task do_reset;
    @(posedge mclk);
    sys_rst <= 1'b1;
    icyc_en <= 1'b1;
    sleep <= 1'b0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  initial begin
    n = $urandom(95813);
    do_reset();
    apb(1'b0, WDCM_OFS_SVC, 32'h00000000);
    chk("svc after reset", exp_svc(WDCM_WIN_RST, WDCM_CM_RST), rd);
    apb(1'b0, 8'h0c, 32'h00000000);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // Random window is locked by the first write, then serviced in window
    win = 2'($urandom % 4);
    svc({win, WDCM_KEY_VAL, 1'b1});
    apb(1'b0, WDCM_OFS_SVC, 32'h00000000);
    chk("svc locked", exp_svc(win, 1'b1), rd);
    repeat (3) begin
      n = 300 + $urandom % 500;
      wait_oe(1'b1, n, t);
      chk("quiet in window", n, t);
      svc({win, WDCM_KEY_VAL, 1'b1});
    end
    // The last valid service must not trip either
    wait_oe(1'b1, 20, t);
    chk("last service quiet", 20, t);
    $display("test window services done");
    // Timeout at the smallest window, then pulse length with a write inside
    do_reset();
    svc(8'h19);
    wait_oe(1'b1, 8300, t);
    chk("timeout", 32'h1, {31'h0, t >= 8185 && t <= 8200});
    chk("pin drive", 32'h0, {31'h0, pin_o});
    svc(8'h1b);
    wait_oe(1'b0, 100, t);
    repeat (2) @(posedge mclk);
    chk("hold length", 32'h1, {31'h0, hi_len >= 16 && hi_len <= 34});
    wait_oe(1'b1, 300, t);
    chk("restart quiet", 300, t);
    $display("test timeout done");
    // Wrong window, monitor, key, early service, bad first key
    for (int i = 0; i < 5; i++) begin
      do_reset();
      if (i < 4) begin
        svc(8'h19);
        repeat (i == 3 ? 100 : 300) @(posedge mclk);
      end
      svc(i < 4 ? bad[i] : 8'h1b);
      wait_oe(1'b1, 6, t);
      chk("bad service trip", 32'h1, {31'h0, pin_oe});
    end
    $display("test bad services done");
    // Dead clock after reset, then recovery
    do_reset();
    icyc_en <= 1'b0;
    wait_oe(1'b1, 260, t);
    chk("clock error", 32'h1, {31'h0, pin_oe});
    @(posedge mclk);
    icyc_en <= 1'b1;
    wait_oe(1'b0, 100, t);
    chk("clock recover", 32'h1, {31'h0, t >= 16 && t <= 40});
    // Monitor switched off by the first write
    do_reset();
    svc(8'h18);
    icyc_en <= 1'b0;
    wait_oe(1'b1, 300, t);
    chk("monitor off", 300, t);
    $display("test clock monitor done");
    // Watchdog disabled by option bit
    do_reset();
    apb(1'b1, WDCM_OFS_OPT, 32'h00000004);
    svc(8'h1b);
    wait_oe(1'b1, 50, t);
    chk("watchdog disabled", 50, t);
    // Light sleep freezes the count; its exit acts as a service.
    // The count is past the lower limit before sleep, so only a wake
    // service can make the following write early.
    do_reset();
    svc(8'h19);
    repeat (300) @(posedge mclk);
    sleep <= 1'b1;
    wait_oe(1'b1, 9000, t);
    chk("sleep quiet", 9000, t);
    @(posedge mclk);
    sleep <= 1'b0;
    repeat (20) @(posedge mclk);
    svc(8'h19);
    wait_oe(1'b1, 6, t);
    chk("early after wake", 32'h1, {31'h0, pin_oe});
    $display("test options and sleep done");
    finish_test();
  end
endmodule // test_wdcm_top

`default_nettype wire

// [wdcm_fault_sink.sv]
// Far-side model: open-drain fault line with its weak pull-up
`timescale 1ns/1ps
`default_nettype none

module wdcm_fault_sink (
  // Device side of the pin
  input wire logic pin_o,
  input wire logic pin_oe,
  // Resolved line level
  output logic pin
);
  // pull-up unless pulled low
  // The line never shows a stale driven high, only the pull-up level
  assign pin = (pin_oe && !pin_o) ? 1'b0 : 1'b1;
endmodule // wdcm_fault_sink

`default_nettype wire

// [wdcm_pkg.sv]
// Constants, field layout and carrier types of the windowed watchdog with clock monitor
package wdcm_pkg;

  // Register byte addresses
  localparam logic [7:0] WDCM_OFS_SVC = 8'h00;
  localparam logic [7:0] WDCM_OFS_OPT = 8'h04;
  localparam logic [7:0] WDCM_OFS_STAT = 8'h08;

  // Service register field positions
  localparam int WDCM_SVC_WIN_HI = 7;
  localparam int WDCM_SVC_WIN_LO = 6;
  localparam int WDCM_SVC_KEY_HI = 5;
  localparam int WDCM_SVC_KEY_LO = 1;
  localparam int WDCM_SVC_CM_BIT = 0;
  localparam logic [4:0] WDCM_KEY_VAL = 5'h0c;

  // Values after reset: widest window, clock monitor on
  localparam logic [1:0] WDCM_WIN_RST = 2'h3;
  localparam logic WDCM_CM_RST = 1'b1;

  // Option configuration register bit positions and reset value
  localparam int WDCM_OPT_WD_DIS = 2;
  localparam int WDCM_OPT_RC_OSC = 3;
  localparam int WDCM_OPT_DLY = 4;
  localparam logic [4:0] WDCM_OPT_RST = 5'h00;

  // Window timing in instruction cycles
  localparam int WDCM_CNT_W = 17;
  localparam logic [16:0] WDCM_LOWER_CYC = 17'h00100;
  localparam logic [16:0] WDCM_UPPER_BASE = 17'h02000;
  localparam logic [4:0] WDCM_HOLD_CYC = 5'h10;

  // Clock monitor: gap between instruction cycles that counts as a dead clock
  localparam int WDCM_CLK_MHZ = 25;
  localparam int WDCM_CM_LIMIT_US = 1000;
  localparam int WDCM_CM_LIMIT_CYC = WDCM_CM_LIMIT_US * WDCM_CLK_MHZ;
  localparam int WDCM_GAP_W = 24;

  // Fault pin sequencer states
  typedef enum logic [1:0] {
    WDCM_IDLE,
    WDCM_PULL,
    WDCM_HOLD,
    WDCM_REL
  } wdcm_state_t;

  // Service register contents
  typedef struct packed {
    logic [1:0] win;
    logic [4:0] key;
    logic cm;
  } wdcm_svc_t;

  // Upper service limit for a window select code
  function automatic logic [16:0] wdcm_upper(input logic [1:0] win);
    wdcm_upper = WDCM_UPPER_BASE << win;
  endfunction

endpackage

// [wdcm_top.sv]
// Windowed watchdog with clock-failure monitor and open-drain fault output
//
// Overview of operation
// - Service register: window select bits 7:6, key bits 5:1, monitor select bit 0.
// - Every service write must carry key pattern 01100 in bits 5:1.
// - Services closer than 256 instruction cycles count as early.
// - Window select 00/01/10/11 gives upper limit 8k/16k/32k/64k cycles.
// - Monitor select bit 0 disables, 1 enables the clock monitor.
// - Watchdog works only when option bit 2 is zero; then it owns the pin.
// - Reset holds watchdog and clock monitor inactive, no error reported.
// - After reset: widest window selected, clock monitor enabled.
// - First write after reset with correct key locks window and monitor enable.
// - Later writes are compared with locked fields and key, never stored.
// - Full match restarts the window; any field mismatch raises a watchdog error.
// - No service before the upper limit raises a watchdog error.
// - A service earlier than the lower limit raises an error; the first write after reset is not checked for this.
// - The configuring first write is also a service and restarts timing.
// - Fault output is active low, released to pull-up, never driven high.
// - On trigger drive low, then 16 to 32 cycles after sensed low release.
// - When the released pin reads high again the window restarts.
// - Service writes while the pin is low are ignored completely.
// - If the pin starts low, the watchdog times out and releases it.
// - Monitor error holds pin low; release 16 to 32 cycles after recovery.
// - Never reject 10 kHz or faster; always reject slower than 10 Hz.
// - Reading the service register shows zero in the key field.
// - Watchdog frozen in both sleep modes; clock monitor stays active.
// - Leaving light sleep performs a hardware service.
// - After full stop resume count only with R/C oscillator and delay bit clear.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module wdcm_top
  import wdcm_pkg::*;
#(
  parameter int CM_LIMIT_CYC = WDCM_CM_LIMIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core timing and power modes
  input wire logic icyc_en,
  input wire logic full_stop_mode,
  input wire logic light_sleep_mode,
  // Fault pin, open drain
  input wire logic fault_output_pin_i,
  output logic fault_output_pin_o,
  output logic fault_output_pin_oe
);

  wdcm_state_t state_reg;
  wdcm_svc_t svc_reg;
  logic locked_reg;
  logic [4:0] opt_reg;
  logic [16:0] cnt_reg;
  logic [4:0] hold_reg;
  logic [23:0] gap_reg;
  logic cm_err_reg;
  logic light_d_reg;
  logic stop_d_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic oe_reg;

  logic access;
  logic mapped;
  logic wr_svc;
  logic svc_take;
  logic key_ok;
  logic all_ok;
  logic early;
  logic wd_on;
  logic wd_run;
  logic timeout;
  logic restart;
  logic svc_err;
  logic wd_trip;
  logic stop_exit;
  logic light_exit;
  logic [16:0] upper;
  wdcm_svc_t wr_fields;

  // APB access phase, one wait state so every answer comes from a flop
  assign access = psel & penable & ~pready_reg;
  assign mapped = (paddr == WDCM_OFS_SVC) | (paddr == WDCM_OFS_OPT) | (paddr == WDCM_OFS_STAT);
  // Write commits on the edge where pready is seen high
  assign wr_svc = psel & penable & pready_reg & pwrite & (paddr == WDCM_OFS_SVC);

  assign wr_fields = wdcm_svc_t'(pwdata[7:0]);
  assign key_ok = (wr_fields.key == WDCM_KEY_VAL);
  assign all_ok = key_ok & (wr_fields.win == svc_reg.win) & (wr_fields.cm == svc_reg.cm);
  // lower limit
  // The 256-cycle figure is used; the larger lower figure beside the windows is not
  assign early = (cnt_reg < WDCM_LOWER_CYC);

  // option bit gates the whole watchdog
  assign wd_on = ~opt_reg[WDCM_OPT_WD_DIS];
  assign wd_run = wd_on & (state_reg == WDCM_IDLE) & ~full_stop_mode & ~light_sleep_mode;
  // pin low or sequencer busy: write ignored
  assign svc_take = wr_svc & wd_on & (state_reg == WDCM_IDLE) & fault_output_pin_i;

  assign upper = wdcm_upper(svc_reg.win);
  assign timeout = wd_run & icyc_en & (cnt_reg == upper - 17'h00001);

  // mismatch or early service is an error
  assign svc_err = svc_take & (locked_reg ? (~all_ok | early) : ~key_ok);
  assign wd_trip = svc_err | timeout;

  // falling edge of light sleep is a hardware service
  assign light_exit = light_d_reg & ~light_sleep_mode;
  assign stop_exit = stop_d_reg & ~full_stop_mode;

  // restart sources for the window counter
  assign restart = (svc_take & ~svc_err) | light_exit
    | (stop_exit & ~(opt_reg[WDCM_OPT_RC_OSC] & ~opt_reg[WDCM_OPT_DLY]));

  // APB handshake and error answer for unmapped addresses
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access & ~mapped;
    end
  end

  // Read data, captured as pready rises
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata_reg <= 32'h00000000;
    end else if (access & ~pwrite) begin
      prdata_reg <= 32'h00000000;
      unique case (paddr)
        WDCM_OFS_SVC: prdata_reg[7:0] <= {svc_reg.win, 5'h00, svc_reg.cm};
        WDCM_OFS_OPT: prdata_reg[4:0] <= opt_reg;
        WDCM_OFS_STAT: prdata_reg <= {8'h00, cnt_reg, 2'h0, state_reg, cm_err_reg,
          oe_reg, locked_reg};
        default: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  // Option configuration register, freely writable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      opt_reg <= WDCM_OPT_RST;
    end else if (psel & penable & pready_reg & pwrite & (paddr == WDCM_OFS_OPT)) begin
      opt_reg <= pwdata[4:0];
    end
  end

  // Service register and lock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      svc_reg <= '{win: WDCM_WIN_RST, key: 5'h00, cm: WDCM_CM_RST};
      locked_reg <= 1'b0;
    end else if (svc_take & ~locked_reg & key_ok) begin
      // one-time load of window and monitor enable
      svc_reg <= '{win: wr_fields.win, key: 5'h00, cm: wr_fields.cm};
      locked_reg <= 1'b1;
    end
  end

  // Sleep-mode edge detectors
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      light_d_reg <= 1'b0;
      stop_d_reg <= 1'b0;
    end else begin
      light_d_reg <= light_sleep_mode;
      stop_d_reg <= full_stop_mode;
    end
  end

  // Window counter in instruction cycles; frozen while faulted or asleep
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_reg <= 17'h00000;
    end else if (restart | (state_reg == WDCM_REL & fault_output_pin_i)) begin
      // restart once the pin is high again
      cnt_reg <= 17'h00000;
    end else if (wd_run & icyc_en & ~timeout) begin
      cnt_reg <= cnt_reg + 17'h00001;
    end
  end

  // Clock monitor: mclk cycles since the last instruction cycle
  // A stopped core clock still shows here, since mclk is the reference
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gap_reg <= 24'h000000;
      cm_err_reg <= 1'b0;
    end else begin
      if (icyc_en) begin
        gap_reg <= 24'h000000;
      end else if (gap_reg != 24'hffffff) begin
        gap_reg <= gap_reg + 24'h000001;
      end
      // limit sits between 100 us and 100 ms
      cm_err_reg <= wd_on & svc_reg.cm & ~icyc_en & (gap_reg >= CM_LIMIT_CYC[23:0]);
    end
  end

  // Fault pin sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= WDCM_IDLE;
      hold_reg <= 5'h00;
      oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        WDCM_IDLE: begin
          // either source pulls the shared pin
          if (wd_trip | cm_err_reg) begin
            state_reg <= WDCM_PULL;
            oe_reg <= 1'b1;
          end
        end
        WDCM_PULL: begin
          // hold count starts once the pin reads low
          hold_reg <= 5'h00;
          if (~fault_output_pin_i) begin
            state_reg <= WDCM_HOLD;
          end
        end
        WDCM_HOLD: begin
          if (cm_err_reg) begin
            // stay low while the clock is bad
            hold_reg <= 5'h00;
          end else if (icyc_en) begin
            if (hold_reg == WDCM_HOLD_CYC - 5'h01) begin
              state_reg <= WDCM_REL;
              oe_reg <= 1'b0;
            end else begin
              hold_reg <= hold_reg + 5'h01;
            end
          end
        end
        WDCM_REL: begin
          // a pin held low outside waits here for its rise
          if (fault_output_pin_i) begin
            state_reg <= WDCM_IDLE;
          end
        end
      endcase
    end
  end

  // only ever drives low; high comes from the pull-up
  always_ff @(posedge mclk) begin
    fault_output_pin_o <= 1'b0;
  end

  assign fault_output_pin_oe = oe_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Key field always reads back zero
  property p_key_hidden;
    pready_reg & ~pwrite & (paddr == WDCM_OFS_SVC) |-> prdata_reg[5:1] == 5'h00;
  endproperty
  a_key_hidden: assert property (p_key_hidden) else $error("key readable");

  // First keyed write locks the new window
  property p_first_lock;
    svc_take & ~locked_reg & key_ok |=> locked_reg & (svc_reg.win == $past(wr_fields.win));
  endproperty
  a_first_lock: assert property (p_first_lock) else $error("first write not locked");

  // Locked write with a wrong field pulls the pin next cycle
  property p_mismatch;
    svc_take & locked_reg & ~all_ok |=> oe_reg & (state_reg == WDCM_PULL);
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

  // Correct service inside the lower limit is an error
  property p_early;
    svc_take & locked_reg & all_ok & (cnt_reg < WDCM_LOWER_CYC) |=> oe_reg;
  endproperty
  a_early: assert property (p_early) else $error("early service accepted");

  // Counter never passes the upper limit
  property p_upper;
    cnt_reg < upper;
  endproperty
  a_upper: assert property (p_upper) else $error("window overran");

  // Pin is never driven high
  property p_low_only;
    fault_output_pin_oe |-> fault_output_pin_o == 1'b0;
  endproperty
  a_low_only: assert property (p_low_only) else $error("pin driven high");

  // Last hold cycle without clock error releases the pin
  property p_release;
    (state_reg == WDCM_HOLD) & icyc_en & ~cm_err_reg & (hold_reg == 5'h0f)
      |=> ~oe_reg ##1 (state_reg != WDCM_HOLD);
  endproperty
  a_release: assert property (p_release) else $error("hold not released");

  // Writes while the pin is low leave the lock untouched
  property p_ignore;
    wr_svc & ~fault_output_pin_i |=> $stable(locked_reg) & $stable(svc_reg);
  endproperty
  a_ignore: assert property (p_ignore) else $error("write taken while low");

  // Clock error in idle pulls the pin at the next edge
  property p_cm_pull;
    cm_err_reg & (state_reg == WDCM_IDLE) |=> oe_reg;
  endproperty
  a_cm_pull: assert property (p_cm_pull) else $error("clock error not shown");

  // Reset release leaves widest window, monitor on, pin free
  property p_reset_state;
    $fell(sys_rst) |-> (svc_reg.win == WDCM_WIN_RST) & svc_reg.cm & ~oe_reg & ~locked_reg;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");

  // Expiry of the upper limit pulls the pin at the next edge
  property p_timeout;
    timeout |=> oe_reg & (state_reg == WDCM_PULL);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");

  // Clock error during the hold keeps the pin low and the count at zero
  property p_cm_hold;
    (state_reg == WDCM_HOLD) & cm_err_reg |=> oe_reg & (hold_reg == 5'h00);
  endproperty
  a_cm_hold: assert property (p_cm_hold) else $error("hold ran in clock error");

  // Count is frozen in either sleep mode unless something restarts it
  property p_sleep_freeze;
    (light_sleep_mode | full_stop_mode) & ~restart & (state_reg != WDCM_REL)
      |=> $stable(cnt_reg);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("count ran asleep");

  // Leaving light sleep restarts the window like a service
  property p_wake_service;
    light_exit |=> cnt_reg == 17'h00000;
  endproperty
  a_wake_service: assert property (p_wake_service) else $error("no wake service");

  // A disabled watchdog never starts a new fault
  property p_disabled;
    ~wd_on & ~cm_err_reg & (state_reg == WDCM_IDLE) |=> ~oe_reg;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled watchdog tripped");

endmodule // wdcm_top

`default_nettype wire
